/* hdl/bmq_block_memory.v */
// Block memory of 20 kb with two shaped ports, a queue controller
// and single-correct double-detect protection, set up over APB.
// Assumes both user ports and the APB master run on clk_sys.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`include "bmq_consts.vh"
`default_nettype none

// Behaviour
// - 20 kb array; shapes 512x40 down to 16kx1 per port.
// - 512x40 shape allowed only in simple dual-port or queue use.
// - Modes: single port, true dual port, simple dual port, ROM.
// - Port shapes independent; both ports must span equal total bits.
// - Registered read; output register adds exactly one cycle.
// - Output register reset value separate from initial value.
// - Reset leaves array alone, touches output register only when used.
// - Write-first policy shows the written word on the read output.
// - No-change policy holds the read output during a write.
// - Same-cell collisions with a write give undefined results.
// - Queue of 20 kb with pointers and flags, any shape.
// - Queue flags correct for common or unrelated clocks.
// - Sync flag mode gives faster synchronous flags.
// - Protection only in 40-bit simple dual port, 8 check bits.
// - Without protection all 40 bits are user storage.
// - Array preload optional; otherwise contents undefined.
// - Read output initial state loadable apart from the array.
module bmq_block_memory (
  input wire clk_sys, // System clock, 125 MHz
  input wire rst_b, // Synchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB direction
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error on unmapped address
  input wire a_en, // Port A enable
  input wire a_we, // Port A write, or queue push
  input wire a_rst, // Port A output register reset
  input wire [13:0] a_addr, // Port A word address
  input wire [39:0] a_din, // Port A write word
  output wire [39:0] a_dout, // Port A read word
  input wire b_en, // Port B enable, or queue pop
  input wire b_we, // Port B write
  input wire b_rst, // Port B output register reset
  input wire [13:0] b_addr, // Port B word address
  input wire [39:0] b_din, // Port B write word
  output wire [39:0] b_dout, // Port B read word
  output wire fifo_empty, // Queue empty flag
  output wire fifo_full, // Queue full flag
  output wire ecc_sbe, // Single error corrected, with read
  output wire ecc_dbe, // Double error detected, with read
  output wire irq // Level interrupt
);

  // ----------------------------------------
  // Shape helpers
  // ----------------------------------------
  // Shape codes 0..10: 40,20,18,16,10,9,8,5,4,2,1 bits wide
  function [5:0] sh_w;
    input [3:0] c;
    begin
      case (c)
        4'h0: sh_w = 6'h28;
        4'h1: sh_w = 6'h14;
        4'h2: sh_w = 6'h12;
        4'h3: sh_w = 6'h10;
        4'h4: sh_w = 6'h0a;
        4'h5: sh_w = 6'h09;
        4'h6: sh_w = 6'h08;
        4'h7: sh_w = 6'h05;
        4'h8: sh_w = 6'h04;
        4'h9: sh_w = 6'h02;
        default: sh_w = 6'h01;
      endcase
    end
  endfunction

  // Slot pitch in the flat array; narrow shapes leave pad bits
  function [5:0] sh_s;
    input [3:0] c;
    begin
      case (c)
        4'h0: sh_s = 6'h28;
        4'h1, 4'h2, 4'h3: sh_s = 6'h14;
        4'h4, 4'h5, 4'h6: sh_s = 6'h0a;
        4'h7, 4'h8: sh_s = 6'h05;
        4'h9: sh_s = 6'h02;
        default: sh_s = 6'h01;
      endcase
    end
  endfunction

  function [14:0] sh_n;
    input [3:0] c;
    begin
      case (c)
        4'h0: sh_n = 15'h0200;
        4'h1, 4'h2, 4'h3: sh_n = 15'h0400;
        4'h4, 4'h5, 4'h6: sh_n = 15'h0800;
        4'h7, 4'h8: sh_n = 15'h1000;
        4'h9: sh_n = 15'h2000;
        default: sh_n = 15'h4000;
      endcase
    end
  endfunction

  // Total bit class: 20 kb, 18 kb or 16 kb
  function [1:0] sh_g;
    input [3:0] c;
    begin
      case (c)
        4'h0, 4'h1, 4'h4, 4'h7: sh_g = 2'h0;
        4'h2, 4'h5: sh_g = 2'h1;
        default: sh_g = 2'h2;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Protection code helpers
  // ----------------------------------------
  // Hamming position of data bit i, skipping powers of two
  function [5:0] dpos;
    input integer i;
    integer k, n;
    begin
      n = 0;
      dpos = 6'h00;
      for (k = 1; k < 39; k = k + 1) begin
        if ((k & (k - 1)) != 0) begin
          if (n == i) dpos = k[5:0];
          n = n + 1;
        end
      end
    end
  endfunction

  // Six Hamming bits, overall parity, one spare zero
  function [7:0] ecc_chk;
    input [31:0] d;
    integer i, p;
    reg [5:0] h;
    reg [5:0] ps;
    begin
      h = 6'h00;
      for (i = 0; i < 32; i = i + 1) begin
        ps = dpos(i);
        for (p = 0; p < 6; p = p + 1)
          if (ps[p]) h[p] = h[p] ^ d[i];
      end
      ecc_chk = {1'b0, ^{h, d}, h};
    end
  endfunction

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  reg [`BMQ_BITS-1:0] mem; // No reset: contents survive rst_b
  reg [31:0] cfg_ff;
  reg [4:0] st_ff;
  reg [4:0] mask_ff;
  reg [31:0] rva_ff, rvb_ff, iva_ff, ivb_ff;
  reg [8:0] mrow_ff;
  reg [7:0] mhi_ff;
  reg [31:0] prdata_ff;
  reg [39:0] a_lat_ff, b_lat_ff, a_out_ff, b_out_ff;
  reg [13:0] wptr_ff, rptr_ff;
  reg [14:0] cnt_ff;
  reg [1:0] emp_d_ff, ful_d_ff;
  reg sbe_ff, dbe_ff, cfgev_ff;
  reg [39:0] a_rraw, b_rraw, m_rraw, b_fix;
  reg [31:0] rdata;
  reg hit;
  integer i;

  wire [2:0] mode = cfg_ff[`BMQ_CFG_MODE];
  wire [3:0] sha = cfg_ff[`BMQ_CFG_SHA];
  wire [3:0] shb = cfg_ff[`BMQ_CFG_SHB];
  wire is_fifo = (mode == `BMQ_MODE_FIFO);
  wire is_sdp = (mode == `BMQ_MODE_SDP);
  wire two_port = (mode == `BMQ_MODE_TDP) | is_sdp | (mode == `BMQ_MODE_ROM);

  // ----------------------------------------
  // Configuration check
  // ----------------------------------------
  // Illegal setups freeze both ports rather than corrupt the array
  wire bad_40 = ~(is_sdp | is_fifo) & ((sha == 4'h0) | (shb == 4'h0));
  wire bad_tot = two_port & (sh_g(sha) != sh_g(shb));
  wire bad_code = (sha > 4'ha) | (shb > 4'ha) | (mode > `BMQ_MODE_FIFO);
  wire cfg_ok = ~(bad_40 | bad_tot | bad_code);
  // Queue uses shape A on both sides
  wire [3:0] shr = is_fifo ? sha : shb;
  wire ecc_on = cfg_ff[`BMQ_CFG_ECC] & is_sdp & (sha == 4'h0);

  // ----------------------------------------
  // Queue pointers and flags
  // ----------------------------------------
  wire [14:0] na = sh_n(sha);
  wire [14:0] nb = sh_n(shr);
  wire [14:0] na_m1 = na - 15'h0001;
  wire [14:0] nb_m1 = nb - 15'h0001;
  wire q_empty = (cnt_ff == 15'h0000);
  wire q_full = (cnt_ff == na);
  wire push = is_fifo & cfg_ok & a_en & a_we & ~q_full;
  wire pop = is_fifo & cfg_ok & b_en & ~q_empty;
  wire ovf = is_fifo & cfg_ok & a_en & a_we & q_full;
  wire unf = is_fifo & cfg_ok & b_en & q_empty;

  // ----------------------------------------
  // Port access decode
  // ----------------------------------------
  wire a_wr = push | (cfg_ok & a_en & a_we & ~is_fifo &
              (mode != `BMQ_MODE_ROM));
  wire a_rd = cfg_ok & a_en & ~a_we & ~is_sdp & ~is_fifo;
  wire b_wr = cfg_ok & b_en & b_we & (mode == `BMQ_MODE_TDP);
  wire b_rd = pop | (cfg_ok & b_en & ~b_we & two_port);

  wire [13:0] a_ix = is_fifo ? wptr_ff : (a_addr & na_m1[13:0]);
  wire [13:0] b_ix = is_fifo ? rptr_ff : (b_addr & nb_m1[13:0]);
  wire [19:0] a_prod = a_ix * sh_s(sha);
  wire [19:0] b_prod = b_ix * sh_s(shr);
  wire [14:0] a_base = a_prod[14:0];
  wire [14:0] b_base = b_prod[14:0];
  wire [15:0] m_prod = mrow_ff * `BMQ_ROWW;
  wire [14:0] m_base = m_prod[14:0];
  wire [5:0] wa = sh_w(sha);
  wire [5:0] wb = sh_w(shr);
  // Stored word of port A: encoded when protected, raw otherwise
  wire [39:0] a_wdat = ecc_on ? {ecc_chk(a_din[31:0]), a_din[31:0]}
                              : a_din;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite;
  wire cfg_wr = apb_wr & (paddr == `BMQ_A_CFG);
  wire ctl_wr = apb_wr & (paddr == `BMQ_A_CTRL);
  wire mlo_wr = apb_wr & (paddr == `BMQ_A_MLO);
  wire [4:0] st_clr = (apb_wr & (paddr == `BMQ_A_STAT)) ? pwdata[4:0] : 5'h00;
  wire ld_ia = ctl_wr & pwdata[0];
  wire ld_ib = ctl_wr & pwdata[1];
  wire [4:0] st_ev;

  // ----------------------------------------
  // Array writes
  // ----------------------------------------
  // A write on B after A to one cell keeps B; collisions are user's job
  always @(posedge clk_sys) begin
    for (i = 0; i < 40; i = i + 1) begin
      if (a_wr && (i < wa)) mem[a_base + i] <= a_wdat[i];
      if (b_wr && (i < wb)) mem[b_base + i] <= b_din[i];
      if (mlo_wr) mem[m_base + i] <= (i < 32) ? pwdata[i] : mhi_ff[i - 32];
    end
  end

  // ----------------------------------------
  // Array reads
  // ----------------------------------------
  // Unused upper bits of narrow shapes read as zero
  always @* begin
    a_rraw = 40'h00_0000_0000;
    b_rraw = 40'h00_0000_0000;
    m_rraw = 40'h00_0000_0000;
    for (i = 0; i < 40; i = i + 1) begin
      if (i < wa) a_rraw[i] = mem[a_base + i];
      if (i < wb) b_rraw[i] = mem[b_base + i];
      m_rraw[i] = mem[m_base + i];
    end
  end

  // Syndrome decode for port B
  wire [7:0] b_chk = ecc_chk(b_rraw[31:0]);
  wire [5:0] syn = b_rraw[37:32] ^ b_chk[5:0];
  wire ovp = ^b_rraw[38:0];
  wire sbe_now = ecc_on & b_rd & ovp;
  wire dbe_now = ecc_on & b_rd & ~ovp & (syn != 6'h00);

  // Flip the one data bit the syndrome points at
  always @* begin
    b_fix = {8'h00, b_rraw[31:0]};
    for (i = 0; i < 32; i = i + 1)
      if (ovp && (dpos(i) == syn)) b_fix[i] = ~b_rraw[i];
  end

  // ----------------------------------------
  // Read latches, first registered stage
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      a_lat_ff <= {8'h00, `BMQ_INIT_RST};
      b_lat_ff <= {8'h00, `BMQ_INIT_RST};
    end else begin
      if (ld_ia) begin
        a_lat_ff <= {8'h00, iva_ff};
      end else if (a_wr) begin
        if (cfg_ff[`BMQ_CFG_WFA]) a_lat_ff <= a_din & ~({40{1'b1}} << wa);
      end else if (a_rd) begin
        a_lat_ff <= a_rraw;
      end
      // No-change policy: nothing is loaded on a write
      if (ld_ib) begin
        b_lat_ff <= {8'h00, ivb_ff};
      end else if (b_wr) begin
        if (cfg_ff[`BMQ_CFG_WFB]) b_lat_ff <= b_din & ~({40{1'b1}} << wb);
      end else if (b_rd) begin
        b_lat_ff <= ecc_on ? b_fix : b_rraw;
      end
    end
  end

  // ----------------------------------------
  // Optional output registers
  // ----------------------------------------
  // Port resets reach only these; the array and latches keep state
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      a_out_ff <= {8'h00, `BMQ_RSTV_RST};
      b_out_ff <= {8'h00, `BMQ_RSTV_RST};
    end else begin
      if (ld_ia) a_out_ff <= {8'h00, iva_ff};
      else if (a_rst) a_out_ff <= {8'h00, rva_ff};
      else a_out_ff <= a_lat_ff;
      if (ld_ib) b_out_ff <= {8'h00, ivb_ff};
      else if (b_rst) b_out_ff <= {8'h00, rvb_ff};
      else b_out_ff <= b_lat_ff;
    end
  end

  assign a_dout = cfg_ff[`BMQ_CFG_OREGA] ? a_out_ff : a_lat_ff;
  assign b_dout = cfg_ff[`BMQ_CFG_OREGB] ? b_out_ff : b_lat_ff;

  // ----------------------------------------
  // Queue pointer logic
  // ----------------------------------------
  // Any configuration write empties the queue so pointers match shape
  always @(posedge clk_sys) begin
    if (!rst_b || cfg_wr) begin
      wptr_ff <= 14'h0000;
      rptr_ff <= 14'h0000;
      cnt_ff <= 15'h0000;
    end else begin
      if (push) wptr_ff <= (wptr_ff == na_m1[13:0]) ? 14'h0000 : wptr_ff + 14'h0001;
      if (pop) rptr_ff <= (rptr_ff == na_m1[13:0]) ? 14'h0000 : rptr_ff + 14'h0001;
      if (push && !pop) cnt_ff <= cnt_ff + 15'h0001;
      else if (pop && !push) cnt_ff <= cnt_ff - 15'h0001;
    end
  end

  // Delayed flag copies model a crossing; they only widen assertion
  // A configuration write empties the queue, so stale full copies go too
  always @(posedge clk_sys) begin
    if (!rst_b || cfg_wr) begin
      emp_d_ff <= 2'h3;
      ful_d_ff <= 2'h0;
    end else begin
      emp_d_ff <= {emp_d_ff[0], q_empty};
      ful_d_ff <= {ful_d_ff[0], q_full};
    end
  end

  // Flags set at once, clear late unless sync mode is chosen
  assign fifo_empty = cfg_ff[`BMQ_CFG_SYNC] ? q_empty : (q_empty | (|emp_d_ff));
  assign fifo_full = cfg_ff[`BMQ_CFG_SYNC] ? q_full : (q_full | (|ful_d_ff));

  // ----------------------------------------
  // Error indications and status
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      sbe_ff <= 1'b0;
      dbe_ff <= 1'b0;
      cfgev_ff <= 1'b0;
    end else begin
      sbe_ff <= sbe_now;
      dbe_ff <= dbe_now;
      cfgev_ff <= cfg_wr & ((pwdata[7:4] > 4'ha) | (pwdata[11:8] > 4'ha));
    end
  end

  assign ecc_sbe = sbe_ff;
  assign ecc_dbe = dbe_ff;
  assign st_ev = {cfgev_ff | (~cfg_ok & (a_en | b_en)), unf, ovf, dbe_now, sbe_now};

  // Set wins over a clear arriving in the same cycle
  always @(posedge clk_sys) begin
    if (!rst_b) st_ff <= `BMQ_ST_RST;
    else st_ff <= (st_ff & ~st_clr) | st_ev;
  end

  assign irq = |(st_ff & mask_ff);

  // ----------------------------------------
  // Software registers
  // ----------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      cfg_ff <= `BMQ_CFG_RST;
      mask_ff <= `BMQ_MASK_RST;
      rva_ff <= `BMQ_RSTV_RST;
      rvb_ff <= `BMQ_RSTV_RST;
      iva_ff <= `BMQ_INIT_RST;
      ivb_ff <= `BMQ_INIT_RST;
      mrow_ff <= 9'h000;
      mhi_ff <= 8'h00;
    end else if (apb_wr) begin
      case (paddr)
        `BMQ_A_CFG: cfg_ff <= {14'h0000, pwdata[17:0]};
        `BMQ_A_MASK: mask_ff <= pwdata[4:0];
        `BMQ_A_RSTV_A: rva_ff <= pwdata;
        `BMQ_A_RSTV_B: rvb_ff <= pwdata;
        `BMQ_A_INIT_A: iva_ff <= pwdata;
        `BMQ_A_INIT_B: ivb_ff <= pwdata;
        `BMQ_A_MROW: mrow_ff <= pwdata[8:0];
        `BMQ_A_MHI: mhi_ff <= pwdata[7:0];
        default: mrow_ff <= mrow_ff;
      endcase
    end
  end

  // Read mux; the queue status word shows live state
  always @* begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    case (paddr)
      `BMQ_A_CFG: rdata = cfg_ff;
      `BMQ_A_STAT: rdata = {27'h0000000, st_ff};
      `BMQ_A_MASK: rdata = {27'h0000000, mask_ff};
      `BMQ_A_QSTAT: rdata = {1'b0, cnt_ff, 13'h0000, ~cfg_ok, q_full, q_empty};
      `BMQ_A_RSTV_A: rdata = rva_ff;
      `BMQ_A_RSTV_B: rdata = rvb_ff;
      `BMQ_A_INIT_A: rdata = iva_ff;
      `BMQ_A_INIT_B: rdata = ivb_ff;
      `BMQ_A_CTRL: rdata = 32'h0000_0000;
      `BMQ_A_MROW: rdata = {23'h000000, mrow_ff};
      `BMQ_A_MLO: rdata = m_rraw[31:0];
      `BMQ_A_MHI: rdata = {24'h000000, m_rraw[39:32]};
      default: hit = 1'b0;
    endcase
  end

  // Read data is captured in the setup cycle, stable in access
  always @(posedge clk_sys) begin
    if (!rst_b) prdata_ff <= 32'h0000_0000;
    else if (psel && !penable) prdata_ff <= rdata;
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = apb_acc & ~hit;

endmodule // bmq_block_memory

`default_nettype wire

/* hdl/bmq_consts.vh */
// Constants of the block memory with queue and error protection.
// Assumes inclusion by bare name from the block memory design file.
`ifndef BMQ_CONSTS_VH
`define BMQ_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define BMQ_A_CFG 8'h00
`define BMQ_A_STAT 8'h04
`define BMQ_A_MASK 8'h08
`define BMQ_A_QSTAT 8'h0c
`define BMQ_A_RSTV_A 8'h10
`define BMQ_A_RSTV_B 8'h14
`define BMQ_A_INIT_A 8'h18
`define BMQ_A_INIT_B 8'h1c
`define BMQ_A_CTRL 8'h20
`define BMQ_A_MROW 8'h24
`define BMQ_A_MLO 8'h28
`define BMQ_A_MHI 8'h2c

// ----------------------------------------
// Configuration fields
// ----------------------------------------
`define BMQ_CFG_MODE 2:0
`define BMQ_CFG_SHA 7:4
`define BMQ_CFG_SHB 11:8
`define BMQ_CFG_OREGA 12
`define BMQ_CFG_OREGB 13
`define BMQ_CFG_WFA 14
`define BMQ_CFG_WFB 15
`define BMQ_CFG_ECC 16
`define BMQ_CFG_SYNC 17
`define BMQ_CFG_RST 32'h0000_0110

// Memory modes
`define BMQ_MODE_SP 3'h0
`define BMQ_MODE_TDP 3'h1
`define BMQ_MODE_SDP 3'h2
`define BMQ_MODE_ROM 3'h3
`define BMQ_MODE_FIFO 3'h4

// Status bits, sticky, write one to clear
`define BMQ_ST_SBE 0
`define BMQ_ST_DBE 1
`define BMQ_ST_OVF 2
`define BMQ_ST_UNF 3
`define BMQ_ST_CFG 4
`define BMQ_ST_RST 5'h00
`define BMQ_MASK_RST 5'h00
`define BMQ_RSTV_RST 32'h0000_0000
`define BMQ_INIT_RST 32'h0000_0000

// Geometry
`define BMQ_BITS 20480
`define BMQ_ROWW 16'h0028
`define BMQ_FLAG_LAG 2

`endif

/* dv/bmq_block_memory_properties.sv */
// Checker of the block memory's port timing and flag relations.
// Assumes a bind onto bmq_block_memory; sees only that module's ports.
`default_nettype none
module bmq_mem_props (
  input wire clk_sys, // Clock
  input wire rst_b, // Reset, active low
  input wire psel, // APB select
  input wire penable, // APB access
  input wire pwrite, // APB direction
  input wire pready, // APB ready
  input wire pslverr, // APB error
  input wire a_en, // Port A enable
  input wire a_rst, // Port A output reset
  input wire [39:0] a_dout, // Port A read word
  input wire b_en, // Port B enable or pop
  input wire [39:0] b_dout, // Port B read word
  input wire fifo_empty, // Queue empty
  input wire fifo_full, // Queue full
  input wire ecc_sbe, // Corrected pulse
  input wire ecc_dbe, // Detected pulse
  input wire irq // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Register writes may reload outputs, so quiet cycles exclude them
  sequence quiet_a;
    !a_en && !a_rst && !(psel && penable && pwrite);
  endsequence
  sequence pop_idle;
    !b_en && !(psel && penable && pwrite);
  endsequence
  a_ready_always: assert property (pready) else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable) else $error("stray error");
  a_flags_excl: assert property (!(fifo_empty && fifo_full))
    else $error("empty and full together");
  a_ecc_excl: assert property (!(ecc_sbe && ecc_dbe)) else $error("both ecc flags");
  a_ecc_read: assert property ((ecc_sbe || ecc_dbe) |-> $past(b_en))
    else $error("ecc flag without read");
  // Two quiet cycles cover the extra stage of the output register
  a_dout_hold: assert property (quiet_a ##1 quiet_a |=> $stable(a_dout))
    else $error("read word moved without access");
  a_reset_state: assert property ($rose(rst_b) |-> fifo_empty && !fifo_full && !irq
    && a_dout == 40'h0 && b_dout == 40'h0) else $error("bad state after reset");
  a_irq_fall: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("irq fell without write");
  a_full_hold: assert property (pop_idle [*4] ##0 fifo_full |=> fifo_full)
    else $error("full dropped without pop");
endmodule // bmq_mem_props
`default_nettype wire

/* dv/bmq_fabric_user.sv */
// Partner model: fabric logic driving both memory ports.
// Assumes the bench calls its tasks one at a time, after a clock edge.
`default_nettype none
module bmq_fabric_user (
  input wire logic clk_sys, // Clock
  output logic a_en, // Port A enable
  output logic a_we, // Port A write
  output logic a_rst, // Port A output reset
  output logic [13:0] a_addr, // Port A address
  output logic [39:0] a_din, // Port A data
  output logic b_en, // Port B enable
  output logic b_we, // Port B write
  output logic b_rst, // Port B output reset
  output logic [13:0] b_addr, // Port B address
  output logic [39:0] b_din // Port B data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle ports at time zero
  initial begin
    {a_en, a_we, a_rst, a_addr, a_din} = '0;
    {b_en, b_we, b_rst, b_addr, b_din} = '0;
  end
  // One access per call, so both ports never hit one cell together
  task automatic op(input int p, input logic we, input logic [13:0] ad, input logic [39:0] d);
    @(posedge clk_sys);
    if (p == 0) begin
      {a_en, a_we, a_addr, a_din} <= {1'b1, we, ad, d};
    end else begin
      {b_en, b_we, b_addr, b_din} <= {1'b1, we, ad, d};
    end
    @(posedge clk_sys);
    // Released lines show inverted data so stale values never pass
    if (p == 0) {a_en, a_we, a_addr, a_din} <= {2'b00, ~ad, ~d};
    else {b_en, b_we, b_addr, b_din} <= {2'b00, ~ad, ~d};
  endtask
  task automatic rs(input int p);
    @(posedge clk_sys);
    if (p == 0) a_rst <= 1'b1;
    else b_rst <= 1'b1;
    @(posedge clk_sys);
    {a_rst, b_rst} <= 2'b00;
  endtask
endmodule // bmq_fabric_user
`default_nettype wire

/* dv/test_block_memory_with_fifo_ecc.sv */
// Self-checking bench: APB set-up, port traffic, queue and protection,
// compared with a flat bit-array model. Assumes the design header on the path.
`include "bmq_consts.vh"
`default_nettype none
module test_block_memory_with_fifo_ecc;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, hi, lo;
  logic err;
  logic [13:0] ad;
  logic [39:0] dv, old;
  wire [31:0] prdata;
  wire [39:0] a_din, b_din, a_dout, b_dout;
  wire [13:0] a_addr, b_addr;
  wire pready, pslverr, a_en, a_we, a_rst, b_en, b_we, b_rst;
  wire fifo_empty, fifo_full, ecc_sbe, ecc_dbe, irq;
  int wid[11] = '{40, 20, 18, 16, 10, 9, 8, 5, 4, 2, 1};
  int pit[11] = '{40, 20, 20, 20, 10, 10, 10, 5, 5, 2, 1};
  int dep[11] = '{512, 1024, 1024, 1024, 2048, 2048, 2048, 4096, 4096, 8192, 16384};
  logic [20479:0] flat;
  logic [39:0] q[$];
  int mismatches = 0, checks_done = 0, cyc = 0;
  integer seed = 44;
  bmq_block_memory DUT (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .a_en, .a_we, .a_rst, .a_addr, .a_din, .a_dout, .b_en,
    .b_we, .b_rst, .b_addr, .b_din, .b_dout, .fifo_empty, .fifo_full, .ecc_sbe,
    .ecc_dbe, .irq);
  bmq_fabric_user fab (.clk_sys, .a_en, .a_we, .a_rst, .a_addr, .a_din, .b_en, .b_we,
    .b_rst, .b_addr, .b_din);
  // ----------------------------------------
  // Model and helpers
  // ----------------------------------------
  function automatic void mput(int c, int k, logic [39:0] d);
    for (int i = 0; i < wid[c]; i++) flat[k*pit[c]+i] = d[i];
  endfunction
  function automatic logic [39:0] mget(int c, int k);
    logic [39:0] r;
    r = 40'h0;
    for (int i = 0; i < wid[c]; i++) r[i] = flat[k*pit[c]+i];
    return r;
  endfunction
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic prd(input int p, input logic [13:0] a, input int lat, input logic [39:0] e);
    fab.op(p, 1'b0, a, 40'h0);
    repeat (lat - 1) @(posedge clk_sys);
    #1;
    chk(p == 0 ? a_dout : b_dout, e);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Clock and hang guard; a run needs about 2300 cycles
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      mismatches++;
      end_sim();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    apb(1'b0, `BMQ_A_CFG, 32'h0);
    chk(rd, `BMQ_CFG_RST);
    apb(1'b0, `BMQ_A_QSTAT, 32'h0);
    chk(rd[1:0], 2'b01);
    apb(1'b0, 8'h30, 32'h0);
    chk({err, rd}, 33'h1_0000_0000);
    // Every shape through simple dual port
    for (int c = 0; c < 11; c++) begin
      apb(1'b1, `BMQ_A_CFG, 32'h2 | (c << 4) | (c << 8));
      ad = 14'({$random(seed)} % dep[c]);
      dv = {8'($random(seed)), $random(seed)};
      mput(c, ad, dv);
      fab.op(0, 1'b1, ad, dv);
      prd(1, ad, 1, mget(c, ad));
    end
    apb(1'b1, `BMQ_A_CFG, 32'h0);
    fab.op(0, 1'b0, 14'h0, 40'h0);
    apb(1'b0, `BMQ_A_STAT, 32'h0);
    chk(rd[4], 1'b1);
    apb(1'b1, `BMQ_A_STAT, 32'h1f);
    apb(1'b1, `BMQ_A_CFG, 32'h211);
    fab.op(1, 1'b0, 14'h0, 40'h0);
    apb(1'b0, `BMQ_A_STAT, 32'h0);
    chk(rd[4], 1'b1);
    apb(1'b1, `BMQ_A_STAT, 32'h1f);
    // Two ports with different shapes over the same bits
    apb(1'b1, `BMQ_A_CFG, 32'h411);
    mput(1, 5, dv);
    fab.op(0, 1'b1, 14'd5, dv);
    mput(1, 6, ~dv);
    fab.op(0, 1'b1, 14'd6, ~dv);
    prd(1, 14'd10, 1, mget(4, 10));
    prd(1, 14'd11, 1, mget(4, 11));
    mput(4, 12, dv);
    fab.op(1, 1'b1, 14'd12, dv);
    prd(0, 14'd6, 1, mget(1, 6));
    // Output register with write-first
    apb(1'b1, `BMQ_A_CFG, 32'h5110);
    prd(0, 14'd6, 2, mget(1, 6));
    mput(1, 3, dv);
    fab.op(0, 1'b1, 14'd3, dv);
    #1;
    chk(a_dout, mget(1, 6));
    @(posedge clk_sys);
    #1;
    chk(a_dout, mget(1, 3));
    // No-change keeps the last read word during a write
    apb(1'b1, `BMQ_A_CFG, 32'h0110);
    prd(0, 14'd6, 1, mget(1, 6));
    old = mget(1, 6);
    fab.op(0, 1'b1, 14'd6, dv);
    mput(1, 6, dv);
    #1;
    chk(a_dout, old);
    // Reset value, initial value, and the array surviving reset
    apb(1'b1, `BMQ_A_CFG, 32'h1110);
    apb(1'b1, `BMQ_A_RSTV_A, 32'h000a_5a5a);
    fab.rs(0);
    #1;
    chk(a_dout, 40'h0a5a5a);
    apb(1'b1, `BMQ_A_INIT_A, 32'h0000_3c3c);
    apb(1'b1, `BMQ_A_CTRL, 32'h1);
    #1;
    chk(a_dout, 40'h3c3c);
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    prd(0, 14'd6, 1, mget(1, 6));
    // Read-only mode ignores a write and still reads
    apb(1'b1, `BMQ_A_CFG, 32'h113);
    fab.op(0, 1'b1, 14'd6, ~dv);
    prd(0, 14'd6, 1, mget(1, 6));
    // Queue with same-clock flags: fill, overflow, drain, underflow
    apb(1'b1, `BMQ_A_CFG, 32'h20004);
    apb(1'b1, `BMQ_A_MASK, 32'h0c);
    for (int i = 0; i < 512; i++) begin
      dv = {8'($random(seed)), $random(seed)};
      q.push_back(dv);
      fab.op(0, 1'b1, 14'h0, dv);
    end
    #1;
    chk(fifo_full, 1'b1);
    fab.op(0, 1'b1, 14'h0, ~dv);
    apb(1'b0, `BMQ_A_STAT, 32'h0);
    chk({irq, rd[2]}, 2'b11);
    while (q.size() > 0) begin
      fab.op(1, 1'b0, 14'h0, 40'h0);
      #1;
      chk(b_dout, q.pop_front());
    end
    chk(fifo_empty, 1'b1);
    fab.op(1, 1'b0, 14'h0, 40'h0);
    apb(1'b0, `BMQ_A_STAT, 32'h0);
    chk(rd[3], 1'b1);
    apb(1'b1, `BMQ_A_STAT, 32'h0c);
    #1;
    chk(irq, 1'b0);
    // Lagged flags for separate clocks
    apb(1'b1, `BMQ_A_CFG, 32'h4);
    fab.op(0, 1'b1, 14'h0, dv);
    #1;
    chk(fifo_empty, 1'b1);
    repeat (3) @(posedge clk_sys);
    #1;
    chk(fifo_empty, 1'b0);
    // Protection: clean read, then one and two injected bit errors
    apb(1'b1, `BMQ_A_CFG, 32'h10002);
    fab.op(0, 1'b1, 14'd7, dv);
    prd(1, 14'd7, 1, {8'h0, dv[31:0]});
    apb(1'b1, `BMQ_A_MROW, 32'h7);
    apb(1'b0, `BMQ_A_MHI, 32'h0);
    hi = rd;
    apb(1'b0, `BMQ_A_MLO, 32'h0);
    lo = rd;
    for (int e = 1; e < 4; e += 2) begin
      apb(1'b1, `BMQ_A_MHI, hi);
      apb(1'b1, `BMQ_A_MLO, lo ^ e);
      prd(1, 14'd7, 1, {8'h0, dv[31:0] ^ (e == 1 ? 32'h0 : 32'h3)});
      chk({ecc_dbe, ecc_sbe}, e == 1 ? 2'b01 : 2'b10);
    end
    end_sim();
  end
endmodule // test_block_memory_with_fifo_ecc
bind bmq_block_memory bmq_mem_props u_props (.clk_sys, .rst_b, .psel, .penable, .pwrite,
  .pready, .pslverr, .a_en, .a_rst, .a_dout, .b_en, .b_dout, .fifo_empty, .fifo_full,
  .ecc_sbe, .ecc_dbe, .irq);
`default_nettype wire
